/* status_event_pkg.sv */
// Purpose: shared constants for the status event register bank
// Assumes: 16-bit event and mask registers, register select by index
// Notes: bit positions follow the binary weight of each event
package status_event_pkg;
  localparam int REG_W = 16;
  // register select codes on the host command port
  localparam logic [2:0] SEL_ACQ_EVENT = 3'h0;
  localparam logic [2:0] SEL_SUSPECT_EVENT = 3'h1;
  localparam logic [2:0] SEL_SEQ_EVENT = 3'h2;
  localparam logic [2:0] SEL_ACQ_MASK = 3'h3;
  localparam logic [2:0] SEL_SUSPECT_MASK = 3'h4;
  localparam logic [2:0] SEL_SEQ_MASK = 3'h5;
  // acquisition event bit positions
  localparam int ACQ_OVER_BIT = 0;
  localparam int ACQ_LOW1_BIT = 1;
  localparam int ACQ_HIGH1_BIT = 2;
  localparam int ACQ_LOW2_BIT = 3;
  localparam int ACQ_HIGH2_BIT = 4;
  localparam int ACQ_READY_BIT = 5;
  localparam int ACQ_NONEMPTY_BIT = 7;
  localparam int ACQ_HALF_BIT = 8;
  localparam int ACQ_FULL_BIT = 9;
  localparam int ACQ_UNDER_BIT = 11;
  localparam int ACQ_FHIGH_BIT = 12;
  localparam int ACQ_FLOW_BIT = 13;
  localparam int ACQ_FILTER_BIT = 14;
  // suspect condition bit positions
  localparam int SUS_TEMP_BIT = 4;
  localparam int SUS_CAL_BIT = 8;
  localparam int SUS_WARN_BIT = 14;
  // sequencer state bit positions
  localparam int SEQ_MEAS_BIT = 4;
  localparam int SEQ_TRIG_BIT = 5;
  localparam int SEQ_IDLE_BIT = 10;
  // implemented bits per event register; others read zero
  localparam logic [15:0] ACQ_USED = 16'h7BBF;
  localparam logic [15:0] SUS_USED = 16'h4110;
  localparam logic [15:0] SEQ_USED = 16'h0430;
  // reset values
  localparam logic [15:0] EVENT_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
endpackage

/* event_group.sv */
// Purpose: one event register with its enable mask and summary output
// Assumes: conditions are synchronous to clk; clear pulse from the bus
// Notes: a set in the clearing cycle survives the read-clear
module event_group #(
  parameter logic [15:0] USED = 16'hFFFF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] cond,
  input wire logic read_clear,
  input wire logic mask_we,
  input wire logic [15:0] mask_wdata,
  output logic [15:0] event_r,
  output logic [15:0] mask_r,
  output logic summary_r
);
  logic [15:0] set_now;

  // only assigned positions can ever latch
  assign set_now = cond & USED;

  // sticky latch; read clears but a same-cycle set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      event_r <= status_event_pkg::EVENT_RST;
    end else if (read_clear) begin
      event_r <= set_now;
    end else begin
      event_r <= event_r | set_now;
    end
  end

  // whole-word mask write, value by binary weight
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= status_event_pkg::MASK_RST;
    end else if (mask_we) begin
      mask_r <= mask_wdata;
    end
  end

  // summary registered from the current event and mask, one edge behind them
  always_ff @(posedge clk) begin
    if (rst) begin
      summary_r <= 1'b0;
    end else begin
      summary_r <= |(event_r & mask_r & USED);
    end
  end

  sticky_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!read_clear && !rst) ##1 1'b1 |-> ((event_r & $past(event_r)) ==
      $past(event_r)))
    else $error("event bit dropped without a read");
  unused_zero_a: assert property (@(posedge clk) disable iff (rst)
    (event_r & ~USED) == 16'h0000)
    else $error("unassigned event bit set");
  mask_block_a: assert property (@(posedge clk) disable iff (rst)
    ((event_r & mask_r & USED) == 16'h0000) |=> !summary_r)
    else $error("summary raised by masked event");
  mask_pass_a: assert property (@(posedge clk) disable iff (rst)
    ((event_r & mask_r) != 16'h0000) |=> summary_r)
    else $error("enabled event did not raise summary");
endmodule

/* instrument_status_event_regs.sv */
// Purpose: three status event registers with enable masks and summaries
// Assumes: host command port: one-cycle read or write strobe with select
// Notes: conditions come from instrument logic on clk, no synchroniser
//
// Functional notes
// - reading an event register returns then clears it
// - value is unsigned, bit n weighs two to n
// - B0 flags result beyond range capability
// - B1-B4 flag low1, high1, low2, high2 limits
// - B5 flags each processed result
// - B7 flags two or more stored results
// - B8 half full, B9 full trace store
// - B11 flags result too small for range
// - B12 fundamental too high, B13 too low
// - B14 flags frequency outside weighting filter
// - suspect B4 flags invalid reference junction
// - suspect B8 holds until good recalibration
// - suspect B14 flags discarded command parameter
// - fault lamp lit while questionable event present
// - sequencer B4 while acquisition in progress
// - sequencer B5 while in device action stage
// - sequencer B10 while sequencer is idle
// - mask written as one weighted integer
// - cleared mask bit blocks the summary
// - set mask bit passes event to summary
// - masks read back last programmed value
module instrument_status_event_regs (
  input wire logic clk,
  input wire logic rst,
  // host command port
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [2:0] host_sel,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata_r,
  output logic host_rvalid_r,
  // acquisition conditions
  input wire logic result_over_range,
  input wire logic below_first_lower_bound,
  input wire logic above_first_upper_bound,
  input wire logic below_second_lower_bound,
  input wire logic above_second_upper_bound,
  input wire logic new_result_ready,
  input wire logic [15:0] trace_count,
  input wire logic [15:0] trace_capacity,
  input wire logic result_under_range,
  input wire logic fundamental_too_high,
  input wire logic fundamental_too_low,
  input wire logic weighting_filter_fault,
  // suspect conditions
  input wire logic junction_invalid,
  input wire logic cal_constant_bad,
  input wire logic recal_done,
  input wire logic param_discarded,
  // sequencer state
  input wire logic acquiring,
  input wire logic device_action,
  input wire logic seq_idle,
  // summaries and lamp
  output logic acq_summary_r,
  output logic suspect_summary_r,
  output logic seq_summary_r,
  output logic fault_lamp_r
);
  logic [15:0] acq_cond;
  logic [15:0] sus_cond;
  logic [15:0] seq_cond;
  logic [15:0] acq_event, sus_event, seq_event;
  logic [15:0] acq_mask, sus_mask, seq_mask;
  logic cal_bad_r;
  logic [16:0] half_cap;
  logic rd_acq, rd_sus, rd_seq;
  logic wr_acq_m, wr_sus_m, wr_seq_m;

  // bus decode: one-cycle strobes per register
  assign rd_acq = host_rd && host_sel == status_event_pkg::SEL_ACQ_EVENT;
  assign rd_sus = host_rd &&
    host_sel == status_event_pkg::SEL_SUSPECT_EVENT;
  assign rd_seq = host_rd && host_sel == status_event_pkg::SEL_SEQ_EVENT;
  assign wr_acq_m = host_wr && host_sel == status_event_pkg::SEL_ACQ_MASK;
  assign wr_sus_m = host_wr &&
    host_sel == status_event_pkg::SEL_SUSPECT_MASK;
  assign wr_seq_m = host_wr && host_sel == status_event_pkg::SEL_SEQ_MASK;

  // half capacity compared as count*2 >= capacity, avoids rounding
  assign half_cap = {trace_count, 1'b0};

  // acquisition condition vector, each bit at its weight
  always_comb begin
    acq_cond = 16'h0000;
    acq_cond[status_event_pkg::ACQ_OVER_BIT] = result_over_range;
    acq_cond[status_event_pkg::ACQ_LOW1_BIT] =
      below_first_lower_bound;
    acq_cond[status_event_pkg::ACQ_HIGH1_BIT] =
      above_first_upper_bound;
    acq_cond[status_event_pkg::ACQ_LOW2_BIT] =
      below_second_lower_bound;
    acq_cond[status_event_pkg::ACQ_HIGH2_BIT] =
      above_second_upper_bound;
    acq_cond[status_event_pkg::ACQ_READY_BIT] = new_result_ready;
    acq_cond[status_event_pkg::ACQ_NONEMPTY_BIT] =
      trace_count >= 16'h0002;
    acq_cond[status_event_pkg::ACQ_HALF_BIT] = trace_capacity != 16'h0000 &&
      half_cap >= {1'b0, trace_capacity};
    acq_cond[status_event_pkg::ACQ_FULL_BIT] = trace_capacity != 16'h0000 &&
      trace_count >= trace_capacity;
    acq_cond[status_event_pkg::ACQ_UNDER_BIT] = result_under_range;
    acq_cond[status_event_pkg::ACQ_FHIGH_BIT] =
      fundamental_too_high;
    acq_cond[status_event_pkg::ACQ_FLOW_BIT] = fundamental_too_low;
    acq_cond[status_event_pkg::ACQ_FILTER_BIT] =
      weighting_filter_fault;
  end

  // calibration fault is held as a condition until recalibration,
  // so a read-clear alone cannot hide a bad constant
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_bad_r <= 1'b0;
    end else if (cal_constant_bad) begin
      cal_bad_r <= 1'b1;
    end else if (recal_done) begin
      cal_bad_r <= 1'b0;
    end
  end

  // suspect condition vector
  always_comb begin
    sus_cond = 16'h0000;
    sus_cond[status_event_pkg::SUS_TEMP_BIT] = junction_invalid;
    sus_cond[status_event_pkg::SUS_CAL_BIT] =
      cal_bad_r || cal_constant_bad;
    sus_cond[status_event_pkg::SUS_WARN_BIT] = param_discarded;
  end

  // sequencer condition vector
  always_comb begin
    seq_cond = 16'h0000;
    seq_cond[status_event_pkg::SEQ_MEAS_BIT] = acquiring;
    seq_cond[status_event_pkg::SEQ_TRIG_BIT] = device_action;
    seq_cond[status_event_pkg::SEQ_IDLE_BIT] = seq_idle;
  end

  event_group #(.USED(status_event_pkg::ACQ_USED)) acq_grp (
    .clk(clk),
    .rst(rst),
    .cond(acq_cond),
    .read_clear(rd_acq),
    .mask_we(wr_acq_m),
    .mask_wdata(host_wdata),
    .event_r(acq_event),
    .mask_r(acq_mask),
    .summary_r(acq_summary_r)
  );

  event_group #(.USED(status_event_pkg::SUS_USED)) sus_grp (
    .clk(clk),
    .rst(rst),
    .cond(sus_cond),
    .read_clear(rd_sus),
    .mask_we(wr_sus_m),
    .mask_wdata(host_wdata),
    .event_r(sus_event),
    .mask_r(sus_mask),
    .summary_r(suspect_summary_r)
  );

  event_group #(.USED(status_event_pkg::SEQ_USED)) seq_grp (
    .clk(clk),
    .rst(rst),
    .cond(seq_cond),
    .read_clear(rd_seq),
    .mask_we(wr_seq_m),
    .mask_wdata(host_wdata),
    .event_r(seq_event),
    .mask_r(seq_mask),
    .summary_r(seq_summary_r)
  );

  // read data: plain binary word, bit n carries 2**n
  always_ff @(posedge clk) begin
    if (rst) begin
      host_rdata_r <= 16'h0000;
      host_rvalid_r <= 1'b0;
    end else begin
      host_rvalid_r <= host_rd;
      if (host_rd) begin
        case (host_sel)
          status_event_pkg::SEL_ACQ_EVENT: host_rdata_r <= acq_event;
          status_event_pkg::SEL_SUSPECT_EVENT: host_rdata_r <= sus_event;
          status_event_pkg::SEL_SEQ_EVENT: host_rdata_r <= seq_event;
          status_event_pkg::SEL_ACQ_MASK: host_rdata_r <= acq_mask;
          status_event_pkg::SEL_SUSPECT_MASK: host_rdata_r <= sus_mask;
          status_event_pkg::SEL_SEQ_MASK: host_rdata_r <= seq_mask;
          default: host_rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  // lamp tracks the latched suspect events, lags them by one edge
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_lamp_r <= 1'b0;
    end else begin
      fault_lamp_r <= |sus_event;
    end
  end

  // read path: the answer lands one edge after the strobe and the read
  // clears; a condition high in that cycle still wins over the clear
  read_return_a: assert property (@(posedge clk) disable iff (rst)
    rd_acq |=> host_rvalid_r && host_rdata_r == $past(acq_event))
    else $error("event read did not return contents");
  read_clear_a: assert property (@(posedge clk) disable iff (rst)
    (rd_acq && acq_cond == 16'h0000) |=> acq_event == 16'h0000)
    else $error("event register not cleared by read");
  sus_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_sus |=> host_rvalid_r && host_rdata_r == $past(sus_event))
    else $error("suspect read did not return contents");
  sus_clear_a: assert property (@(posedge clk) disable iff (rst)
    (rd_sus && sus_cond == 16'h0000) |=> sus_event == 16'h0000)
    else $error("suspect register not cleared by read");
  seq_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_seq |=> host_rvalid_r && host_rdata_r == $past(seq_event))
    else $error("sequencer read did not return contents");
  seq_clear_a: assert property (@(posedge clk) disable iff (rst)
    (rd_seq && seq_cond == 16'h0000) |=> seq_event == 16'h0000)
    else $error("sequencer register not cleared by read");
  rvalid_pulse_a: assert property (@(posedge clk) disable iff (rst)
    ##1 host_rvalid_r == $past(host_rd))
    else $error("read valid is not a one-cycle answer");
  rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
    !host_rd |=> $stable(host_rdata_r))
    else $error("read data changed without a read");
  spare_sel_a: assert property (@(posedge clk) disable iff (rst)
    (host_rd && host_sel > status_event_pkg::SEL_SEQ_MASK) |=>
      host_rdata_r == 16'h0000)
    else $error("spare select did not read zero");
  acq_unused_a: assert property (@(posedge clk) disable iff (rst)
    rd_acq |=> (host_rdata_r & ~status_event_pkg::ACQ_USED) == 16'h0000)
    else $error("unassigned acquisition bit read as set");
  seq_unused_a: assert property (@(posedge clk) disable iff (rst)
    rd_seq |=> (host_rdata_r & ~status_event_pkg::SEQ_USED) == 16'h0000)
    else $error("unassigned sequencer bit read as set");

  // each acquisition condition must reach its own bit at the next edge
  over_flag_a: assert property (@(posedge clk) disable iff (rst)
    result_over_range |=> acq_event[status_event_pkg::ACQ_OVER_BIT])
    else $error("overrange did not set bit 0");
  low1_flag_a: assert property (@(posedge clk) disable iff (rst)
    below_first_lower_bound |=> acq_event[status_event_pkg::ACQ_LOW1_BIT])
    else $error("first low limit did not set bit 1");
  high1_flag_a: assert property (@(posedge clk) disable iff (rst)
    above_first_upper_bound |=> acq_event[status_event_pkg::ACQ_HIGH1_BIT])
    else $error("first high limit did not set bit 2");
  low2_flag_a: assert property (@(posedge clk) disable iff (rst)
    below_second_lower_bound |=> acq_event[status_event_pkg::ACQ_LOW2_BIT])
    else $error("second low limit did not set bit 3");
  high2_flag_a: assert property (@(posedge clk) disable iff (rst)
    above_second_upper_bound |=> acq_event[status_event_pkg::ACQ_HIGH2_BIT])
    else $error("second high limit did not set bit 4");
  ready_flag_a: assert property (@(posedge clk) disable iff (rst)
    new_result_ready |=> acq_event[status_event_pkg::ACQ_READY_BIT])
    else $error("processed result did not set bit 5");
  half_flag_a: assert property (@(posedge clk) disable iff (rst)
    (trace_capacity != 16'h0000 &&
      2 * int'(trace_count) >= int'(trace_capacity)) |=>
      acq_event[status_event_pkg::ACQ_HALF_BIT])
    else $error("half store did not set bit 8");
  full_flag_a: assert property (@(posedge clk) disable iff (rst)
    (trace_capacity != 16'h0000 && trace_count >= trace_capacity) |=>
      acq_event[status_event_pkg::ACQ_FULL_BIT])
    else $error("full store did not set bit 9");
  avail_flag_a: assert property (@(posedge clk) disable iff (rst)
    (trace_count >= 16'h0002) |=>
      acq_event[status_event_pkg::ACQ_NONEMPTY_BIT])
    else $error("two stored results did not set bit 7");
  under_flag_a: assert property (@(posedge clk) disable iff (rst)
    result_under_range |=> acq_event[status_event_pkg::ACQ_UNDER_BIT])
    else $error("underrange did not set bit 11");
  fhigh_flag_a: assert property (@(posedge clk) disable iff (rst)
    fundamental_too_high |=> acq_event[status_event_pkg::ACQ_FHIGH_BIT])
    else $error("high fundamental did not set bit 12");
  flow_flag_a: assert property (@(posedge clk) disable iff (rst)
    fundamental_too_low |=> acq_event[status_event_pkg::ACQ_FLOW_BIT])
    else $error("low fundamental did not set bit 13");
  filter_flag_a: assert property (@(posedge clk) disable iff (rst)
    weighting_filter_fault |=> acq_event[status_event_pkg::ACQ_FILTER_BIT])
    else $error("filter fault did not set bit 14");

  // suspect events; the calibration fault outlives any read-clear
  temp_flag_a: assert property (@(posedge clk) disable iff (rst)
    junction_invalid |=> sus_event[status_event_pkg::SUS_TEMP_BIT])
    else $error("junction fault did not set bit 4");
  cal_flag_a: assert property (@(posedge clk) disable iff (rst)
    cal_constant_bad |=> cal_bad_r &&
      sus_event[status_event_pkg::SUS_CAL_BIT])
    else $error("bad constant did not set bit 8");
  warn_flag_a: assert property (@(posedge clk) disable iff (rst)
    param_discarded |=> sus_event[status_event_pkg::SUS_WARN_BIT])
    else $error("discarded parameter did not set bit 14");
  cal_hold_a: assert property (@(posedge clk) disable iff (rst)
    (cal_bad_r && !recal_done) |=> cal_bad_r ##0
      sus_cond[status_event_pkg::SUS_CAL_BIT])
    else $error("calibration flag dropped early");
  recal_clear_a: assert property (@(posedge clk) disable iff (rst)
    (recal_done && !cal_constant_bad) |=> !cal_bad_r)
    else $error("recalibration did not clear the fault");

  // sequencer events
  meas_flag_a: assert property (@(posedge clk) disable iff (rst)
    acquiring |=> seq_event[status_event_pkg::SEQ_MEAS_BIT])
    else $error("acquisition did not set bit 4");
  trig_flag_a: assert property (@(posedge clk) disable iff (rst)
    device_action |=> seq_event[status_event_pkg::SEQ_TRIG_BIT])
    else $error("device action did not set bit 5");
  idle_flag_a: assert property (@(posedge clk) disable iff (rst)
    seq_idle |=> seq_event[status_event_pkg::SEQ_IDLE_BIT])
    else $error("idle state did not set bit 10");

  // mask readback: a write, one quiet cycle, then a read of that mask
  mask_readback_a: assert property (@(posedge clk) disable iff (rst)
    wr_sus_m ##1 !host_wr ##1 (host_rd && !host_wr &&
      host_sel == status_event_pkg::SEL_SUSPECT_MASK) |=>
      host_rdata_r == $past(host_wdata, 3))
    else $error("mask readback mismatch");
  acq_readback_a: assert property (@(posedge clk) disable iff (rst)
    wr_acq_m ##1 !host_wr ##1 (host_rd && !host_wr &&
      host_sel == status_event_pkg::SEL_ACQ_MASK) |=>
      host_rdata_r == $past(host_wdata, 3))
    else $error("acquisition mask readback mismatch");
  seq_readback_a: assert property (@(posedge clk) disable iff (rst)
    wr_seq_m ##1 !host_wr ##1 (host_rd && !host_wr &&
      host_sel == status_event_pkg::SEL_SEQ_MASK) |=>
      host_rdata_r == $past(host_wdata, 3))
    else $error("sequencer mask readback mismatch");

  // lamp lags the latched suspect events by one edge
  lamp_follow_a: assert property (@(posedge clk) disable iff (rst)
    ##1 fault_lamp_r == (|$past(sus_event)))
    else $error("fault lamp does not follow events");
  lamp_lit_a: assert property (@(posedge clk) disable iff (rst)
    (sus_event != 16'h0000) |=> fault_lamp_r)
    else $error("fault lamp dark while event present");
endmodule

/* host_cmd_model.sv */
// Purpose: host computer model issuing status queries and mask programs
// Assumes: one-cycle strobes taken at the next rising edge of clk
// Notes: read data is registered at the taking edge and sampled 1 ns later, no wait loop
module host_cmd_model (
  input wire logic clk,
  output logic host_rd,
  output logic host_wr,
  output logic [2:0] host_sel,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata_r,
  input wire logic host_rvalid_r
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_sel = 3'h0;
    host_wdata = 16'h0000;
  end
  // query: strobe one cycle, sample the registered answer after next edge
  task automatic rd(input logic [2:0] s, output logic [15:0] d,
                    output logic v);
    @(posedge clk);
    host_rd <= 1'b1;
    host_sel <= s;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    d = host_rdata_r;
    v = host_rvalid_r;
  endtask
  // program: whole mask as one weighted integer; data inverted once idle
  // so a stale value is never mistaken for a fresh one
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_sel <= s;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask
endmodule

/* instrument_status_event_regs_tb.sv */
// Purpose: self-checking bench for the status event register bank
// Assumes: conditions driven on clk; host model drives the command port
// Notes: expectations come from bit weights, never from design outputs
module instrument_status_event_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic host_rd, host_wr, host_rvalid_r;
  logic [2:0] host_sel;
  logic [15:0] host_wdata, host_rdata_r;
  logic [16:0] cond_v = 17'h00000; // one bit per single condition input
  logic [15:0] trace_count = 16'h0000;
  logic [15:0] trace_capacity = 16'h0008;
  logic acq_summary_r, suspect_summary_r, seq_summary_r, fault_lamp_r;
  int error_cnt = 0;
  int checks = 0;
  int pulse_idx = 0; // static index, so the pulse drive is not automatic
  int acq_pos [10] = '{0, 1, 2, 3, 4, 5, 11, 12, 13, 14};
  logic [15:0] seq_exp [3] = '{16'h0010, 16'h0020, 16'h0400};
  always #50 clk = ~clk;
  host_cmd_model u_host (.clk(clk), .host_rd(host_rd), .host_wr(host_wr),
    .host_sel(host_sel), .host_wdata(host_wdata),
    .host_rdata_r(host_rdata_r), .host_rvalid_r(host_rvalid_r));
  instrument_status_event_regs u_dut (.clk(clk), .rst(rst),
    .host_rd(host_rd), .host_wr(host_wr), .host_sel(host_sel),
    .host_wdata(host_wdata), .host_rdata_r(host_rdata_r),
    .host_rvalid_r(host_rvalid_r), .result_over_range(cond_v[0]),
    .below_first_lower_bound(cond_v[1]), .above_first_upper_bound(cond_v[2]),
    .below_second_lower_bound(cond_v[3]),
    .above_second_upper_bound(cond_v[4]), .new_result_ready(cond_v[5]),
    .trace_count(trace_count), .trace_capacity(trace_capacity),
    .result_under_range(cond_v[6]), .fundamental_too_high(cond_v[7]),
    .fundamental_too_low(cond_v[8]), .weighting_filter_fault(cond_v[9]),
    .junction_invalid(cond_v[10]), .cal_constant_bad(cond_v[11]),
    .recal_done(cond_v[12]), .param_discarded(cond_v[13]),
    .acquiring(cond_v[14]), .device_action(cond_v[15]),
    .seq_idle(cond_v[16]), .acq_summary_r(acq_summary_r),
    .suspect_summary_r(suspect_summary_r), .seq_summary_r(seq_summary_r),
    .fault_lamp_r(fault_lamp_r));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // query and compare, including the one-cycle valid pulse
  task automatic rd_chk(input logic [2:0] s, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    u_host.rd(s, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask
  // one-cycle condition, then two edges for event and summary to land
  task automatic pulse(input int i);
    @(posedge clk);
    pulse_idx = i;
    cond_v[pulse_idx] <= 1'b1;
    @(posedge clk);
    cond_v[pulse_idx] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    for (int s = 0; s < 8; s++) rd_chk(s[2:0], 16'h0000);
    check({12'h000, acq_summary_r, suspect_summary_r, seq_summary_r,
          fault_lamp_r}, 16'h0000);
  endtask
  // each of the ten single-input acquisition events alone, latched after its cause went away
  task automatic t_acq;
    for (int i = 0; i < 10; i++) begin
      pulse(i);
      rd_chk(3'h0, 16'h0001 << acq_pos[i]);
      rd_chk(3'h0, 16'h0000);
    end
  endtask
  task automatic trace_chk(input logic [15:0] n, input logic [15:0] exp);
    @(posedge clk);
    trace_count <= n;
    repeat (2) @(posedge clk);
    trace_count <= 16'h0000;
    repeat (2) @(posedge clk);
    rd_chk(3'h0, exp);
  endtask
  task automatic t_trace;
    trace_chk(16'h0001, 16'h0000);
    trace_chk(16'h0002, 16'h0080);
    trace_chk(16'h0004, 16'h0180);
    trace_chk(16'h0008, 16'h0380);
    // no store configured: only the count flag may set
    @(posedge clk);
    trace_capacity <= 16'h0000;
    trace_chk(16'h0008, 16'h0080);
    // half full but not full in a larger store
    @(posedge clk);
    trace_capacity <= 16'h0010;
    trace_chk(16'h0008, 16'h0180);
  endtask
  // lamp follows latched suspect events; calibration fault outlives reads
  task automatic t_suspect;
    pulse(10);
    check({15'h0000, fault_lamp_r}, 16'h0001);
    rd_chk(3'h1, 16'h0010);
    @(posedge clk);
    #1;
    check({15'h0000, fault_lamp_r}, 16'h0000);
    pulse(13);
    rd_chk(3'h1, 16'h4000);
    pulse(11);
    rd_chk(3'h1, 16'h0100);
    rd_chk(3'h1, 16'h0100);
    pulse(12);
    rd_chk(3'h1, 16'h0100);
    rd_chk(3'h1, 16'h0000);
  endtask
  task automatic t_seq;
    for (int i = 0; i < 3; i++) begin
      pulse(14 + i);
      rd_chk(3'h2, seq_exp[i]);
    end
  endtask
  // masks: all-set, all-clear, refused event writes, summary gating
  task automatic t_mask;
    for (int s = 3; s < 6; s++) begin
      u_host.wr(s[2:0], 16'hFFFF);
      rd_chk(s[2:0], 16'hFFFF);
      u_host.wr(s[2:0], 16'h0000);
      rd_chk(s[2:0], 16'h0000);
    end
    u_host.wr(3'h0, 16'hFFFF);
    rd_chk(3'h0, 16'h0000);
    u_host.wr(3'h3, 16'h0220);
    rd_chk(3'h3, 16'h0220);
    pulse(5);
    check({15'h0000, acq_summary_r}, 16'h0001);
    rd_chk(3'h0, 16'h0020);
    pulse(1);
    check({15'h0000, acq_summary_r}, 16'h0000);
    rd_chk(3'h0, 16'h0002);
    u_host.wr(3'h4, 16'h0010);
    pulse(10);
    check({15'h0000, suspect_summary_r}, 16'h0001);
    rd_chk(3'h1, 16'h0010);
    u_host.wr(3'h5, 16'h0400);
    pulse(16);
    check({15'h0000, seq_summary_r}, 16'h0001);
  endtask
  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_acq();
    t_trace();
    t_suspect();
    t_seq();
    t_mask();
    give_verdict();
  end
endmodule
